/* File: design/rtd_pkg.sv */
// Constants and types shared by the relay timing controller.
// Assumes a single 125 MHz clock domain and synchronous inputs.
package rtd_pkg;

  // Clock figures.
  localparam int unsigned CLK_PERIOD_NS = 8;

  // Width of the delay value and timer, in timebase ticks.
  localparam int unsigned DELAY_W = 32;

  // Default timebase tick period in nanoseconds (one millisecond).
  localparam int unsigned TICK_NS = 1000000;
  // Clock cycles per tick, derived from the period and the clock rate.
  localparam int unsigned TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;

  // Reset values.
  localparam logic [DELAY_W-1:0] TIMER_RESET = '0;
  localparam logic               CONTACT_SHELF = 1'b0;

  // Timing function selection.
  typedef enum logic {
    RTD_FUNC_INTERVAL,
    RTD_FUNC_OFF_DELAY
  } rtd_func_t;

  // Controller states.
  typedef enum logic [1:0] {
    RTD_SHELF,
    RTD_HOLD,
    RTD_TIMING
  } rtd_state_t;

endpackage

/* File: design/rtd_relay_timer.sv */
// Relay timing controller: interval and trigger-released off-delay functions.
// Assumes power_on, gate_input and function_select are synchronous to mclk,
// and that delay_period is held steady while a delay runs.

// Summary of operation
// [R1] Interval: energize on power, start timing.
// [R2] Interval: timing starts with the contact change.
// [R3] Interval: contact drops when delay elapses.
// [R4] Interval: power loss drops contact at once.
// [R5] Interval: gate input is ignored.
// [R6] Off-delay: power must stay present throughout.
// [R7] Off-delay: gate closure energizes the contact.
// [R8] Off-delay: gate opening starts the delay.
// [R9] Off-delay: contact drops after undisturbed delay.
// [R10] Off-delay: closure during delay clears elapsed time.
// [R11] Next opening restarts the full delay.
// [R12] Contact never drops during a retrigger.
// [R13] Off-delay: power loss drops contact, abandons timing.
// [R14] Function select input and delay in ticks.
// [R15] Power return starts from shelf, timer cleared.
module rtd_relay_timer #(
  parameter int unsigned TICK_DIVIDE = rtd_pkg::TICK_CYCLES
) (
  input  wire logic                       mclk,
  input  wire logic                       rst_n,
  input  wire logic                       power_on,
  input  wire logic                       gate_input,
  input  wire rtd_pkg::rtd_func_t         function_select,
  input  wire logic [rtd_pkg::DELAY_W-1:0] delay_period,
  output logic                            load_contact,
  output logic                            timing_active
);
  import rtd_pkg::*;

  logic                rst_meta;
  logic                rst_sync_n;
  rtd_state_t          state;
  rtd_state_t          next_state;
  logic [DELAY_W-1:0]  elapsed;
  logic [DELAY_W-1:0]  next_elapsed;
  logic                next_contact;
  logic                power_prev;
  logic                restart;
  logic                tick;

  // Reset release passes through two flops; assertion stays asynchronous.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta   <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta   <= 1'b1;
      rst_sync_n <= rst_meta;
    end
  end

  // The tick phase restarts whenever a delay starts, so a delay is never short.
  rtd_tick_gen #(
    .DIVIDE (TICK_DIVIDE)
  ) u_tick (
    .mclk    (mclk),
    .rst_n   (rst_sync_n),
    .restart (restart),
    .tick    (tick)
  );

  // Next state, elapsed time and contact drive.
  always_comb begin
    next_state   = state;
    next_elapsed = elapsed;
    restart      = 1'b0;
    if (!power_on) begin
      // [R4] [R13] power loss drops.
      // Dropping power abandons any timing in progress.
      next_state   = RTD_SHELF;
      next_elapsed = TIMER_RESET;
    end else begin
      unique case (state)
        RTD_SHELF: begin
          if (function_select == RTD_FUNC_INTERVAL) begin
            // [R1] [R2] start on power.
            // Only a fresh power application starts an interval; the
            // finished interval waits here until power is cycled.
            if (!power_prev) begin
              next_state   = RTD_TIMING;
              next_elapsed = TIMER_RESET;
              restart      = 1'b1;
            end
          end else if (gate_input) begin
            // [R7] gate closure energizes.
            next_state   = RTD_HOLD;
            next_elapsed = TIMER_RESET;
          end
        end
        RTD_HOLD: begin
          if (function_select == RTD_FUNC_INTERVAL) begin
            // A function change while held falls back to the shelf state.
            next_state = RTD_SHELF;
          end else if (!gate_input) begin
            // [R8] [R11] opening starts delay.
            next_state   = RTD_TIMING;
            next_elapsed = TIMER_RESET;
            restart      = 1'b1;
          end
        end
        RTD_TIMING: begin
          // [R5] gate ignored in interval.
          if (function_select == RTD_FUNC_OFF_DELAY && gate_input) begin
            // [R10] [R12] retrigger clears time.
            next_state   = RTD_HOLD;
            next_elapsed = TIMER_RESET;
          end else if (elapsed >= delay_period) begin
            // [R3] [R9] delay elapsed drops.
            next_state   = RTD_SHELF;
            next_elapsed = TIMER_RESET;
          end else if (tick) begin
            next_elapsed = elapsed + DELAY_W'(1);
          end
        end
        // The fourth state code is unused; recover to the shelf state.
        default: begin
          next_state   = RTD_SHELF;
          next_elapsed = TIMER_RESET;
        end
      endcase
    end
    // [R1] [R12] contact follows state.
    next_contact = (next_state != RTD_SHELF) ? 1'b1 : CONTACT_SHELF;
  end

  // [R14] [R15] registered state clears.
  // Registers only; power loss already forces the shelf state and a clear timer.
  always_ff @(posedge mclk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      state         <= RTD_SHELF;
      elapsed       <= TIMER_RESET;
      load_contact  <= CONTACT_SHELF;
      power_prev    <= 1'b0;
      timing_active <= 1'b0;
    end else begin
      state         <= next_state;
      elapsed       <= next_elapsed;
      load_contact  <= next_contact;
      power_prev    <= power_on;
      timing_active <= (next_state == RTD_TIMING);
    end
  end

endmodule

/* File: design/rtd_tick_gen.sv */
// Timebase tick generator for the relay timing controller.
// Assumes a synchronous reset-released clock domain; restart realigns the tick.
module rtd_tick_gen #(
  parameter int unsigned DIVIDE = rtd_pkg::TICK_CYCLES
) (
  input  wire logic mclk,
  input  wire logic rst_n,
  input  wire logic restart,
  output logic      tick
);
  import rtd_pkg::*;

  localparam int unsigned CW = (DIVIDE > 1) ? $clog2(DIVIDE) : 1;
  localparam logic [CW-1:0] LAST = CW'(DIVIDE - 1);

  logic [CW-1:0] count;
  logic [CW-1:0] next_count;
  logic          next_tick;

  // Count cycles; restarting keeps every delay a whole number of ticks long.
  always_comb begin
    next_count = count;
    next_tick  = 1'b0;
    if (restart) begin
      next_count = '0;
    end else if (count == LAST) begin
      next_count = '0;
      next_tick  = 1'b1;
    end else begin
      next_count = count + CW'(1);
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      count <= '0;
      tick  <= 1'b0;
    end else begin
      count <= next_count;
      tick  <= next_tick;
    end
  end

endmodule

/* File: sim/rtd_relay_monitor.sv */
// Checker for the relay timing controller.
// Assumes rtd_pkg is compiled first and one clock domain.
module rtd_relay_monitor
  import rtd_pkg::*;
#(parameter int unsigned TICK_DIVIDE = 4) (
  input wire logic               mclk,
  input wire logic               rst_n,
  input wire logic               power_on,
  input wire logic               gate_input,
  input wire rtd_func_t          function_select,
  input wire logic [DELAY_W-1:0] delay_period,
  input wire logic               load_contact,
  input wire logic               timing_active
);
  logic [1:0]         up;
  logic [DELAY_W-1:0] n;
  logic               od;
  assign od = function_select == RTD_FUNC_OFF_DELAY;
  // Checks wait out the reset synchronizer; n counts cycles spent timing.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      up <= 2'h0;
      n  <= '0;
    end else begin
      up <= {up[0], 1'b1};
      n  <= timing_active ? n + 1'b1 : '0;
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!up[1]);
  sequence s_open;
    od && $past(od) && power_on && $past(power_on) && $fell(gate_input);
  endsequence
  sequence s_done;
    $fell(timing_active) && !load_contact && power_on && $past(power_on);
  endsequence
  a_power_drop: assert property (!power_on |=> !load_contact && !timing_active) else $error("held unpowered");
  a_interval_start: assert property (!od && $rose(power_on) |=> load_contact && timing_active)
    else $error("interval did not start");
  a_interval_idle: assert property (!od && $past(!od) && power_on && $past(power_on) && !load_contact
    |=> !load_contact) else $error("interval restarted");
  a_gate_hold: assert property (od && $past(od) && power_on && $past(power_on) && gate_input
    |=> load_contact && !timing_active) else $error("gate closure ignored");
  a_open_times: assert property (s_open |=> timing_active && load_contact) else $error("no delay");
  a_no_dropout: assert property (timing_active |-> load_contact) else $error("dropout");
  a_delay_len: assert property (s_done |-> n + 2 > delay_period * TICK_DIVIDE
    && n < delay_period * TICK_DIVIDE + 3) else $error("wrong delay length");
  a_shelf_start: assert property ($rose(power_on) && od && !gate_input
    |=> !load_contact && !timing_active) else $error("not from shelf");
endmodule
bind rtd_relay_timer rtd_relay_monitor #(.TICK_DIVIDE(TICK_DIVIDE)) rtd_relay_monitor_i (.mclk(mclk),
  .rst_n(rst_n), .power_on(power_on), .gate_input(gate_input), .function_select(function_select),
  .delay_period(delay_period), .load_contact(load_contact), .timing_active(timing_active));

/* File: sim/rtd_relay_timer_tb.sv */
// Random and corner-case bench for the relay timing controller.
// Assumes rtd_pkg, the switch model and the checker are compiled first.
module rtd_relay_timer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import rtd_pkg::*;
  localparam int TD = 4;
  logic               mclk, rst_n, power_on, close_req, gate_input, load_contact, timing_active;
  rtd_func_t          function_select;
  logic [DELAY_W-1:0] delay_period;
  int                 miscompares, check_count, cyc, seed;
  rtd_switch_model rtd_switch_model_i (.mclk(mclk), .close_req(close_req), .gate_input(gate_input));
  rtd_relay_timer #(.TICK_DIVIDE(TD)) rtd_relay_timer_i (.mclk(mclk), .rst_n(rst_n), .power_on(power_on),
    .gate_input(gate_input), .function_select(function_select), .delay_period(delay_period),
    .load_contact(load_contact), .timing_active(timing_active));
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  function automatic int span(logic [DELAY_W-1:0] p);
    return p * TD;
  endfunction
  task automatic w(int k);
    repeat (k) @(negedge mclk);
  endtask
  task automatic chk(logic got, logic exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // A hung run is cut short well past the expected length.
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      miscompares++;
      stop_test;
    end
  end
  initial begin
    {rst_n, power_on, close_req} = 3'h0;
    seed = 3195;
    function_select = RTD_FUNC_INTERVAL;
    delay_period = 32'h2;
    w(12);
    rst_n = 1'b1;
    w(4);
    repeat (5) begin
      delay_period = DELAY_W'(2 + $unsigned($random(seed)) % 4);
      function_select = RTD_FUNC_INTERVAL;
      power_on = 1'b1;
      w(1);
      chk(load_contact, 1'b1);
      repeat (span(delay_period) - 3) begin
        close_req = 1'($random(seed));
        w(1);
        chk(load_contact, 1'b1);
      end
      w(6);
      chk(load_contact, 1'b0);
      {power_on, close_req} = 2'h0;
      w(2);
      function_select = RTD_FUNC_OFF_DELAY;
      power_on = 1'b1;
      w(2);
      chk(load_contact, 1'b0);
      close_req = 1'b1;
      w(3);
      chk(load_contact, 1'b1);
      repeat (2) begin
        close_req = 1'b0;
        repeat (span(delay_period) - 3) begin
          w(1);
          chk(load_contact, 1'b1);
        end
        close_req = 1'b1;
        w(3);
        chk(timing_active, 1'b0);
      end
      close_req = 1'b0;
      w(span(delay_period) + 4);
      chk(load_contact, 1'b0);
      close_req = 1'b1;
      w(3);
      close_req = 1'b0;
      w(4);
      power_on = 1'b0;
      w(1);
      chk(load_contact, 1'b0);
    end
    w(2);
    stop_test;
  end
endmodule

/* File: sim/rtd_switch_model.sv */
// Trigger switch model that drives the gate input.
// Assumes the bench asks for closures; the contact moves a cycle later.
module rtd_switch_model (
  input  wire logic mclk,
  input  wire logic close_req,
  output logic      gate_input
);
  timeunit 1ns;
  timeprecision 1ps;
  logic q;
  initial gate_input = 1'b0;
  // The lever is read on the rise, so the contact lags like a hand would.
  always @(posedge mclk) q <= close_req;
  always @(negedge mclk) gate_input <= q;
endmodule
